// ===== common/stepper_pkg.sv
// Shared constants, register map and types for the stepper position monitor
package stepper_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ         = 125_000_000;  // Core clock rate
  localparam int unsigned MS_PER_S       = 1000;         // Unit conversion
  localparam int unsigned CYC_PER_MS     = CLK_HZ / MS_PER_S;  // Cycles in one ms
  localparam int unsigned SETTLE_MS      = 500;          // Excitation settle time
  localparam int unsigned SETTLE_CYCLES  = SETTLE_MS * CYC_PER_MS;
  localparam int unsigned DEG_TENTHS_REV = 3600;         // Band unit is 0.1 deg

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG   = 8'h00;  // Mode and selection bits
  localparam logic [7:0] OFS_SPD_FILT = 8'h04;  // Speed filter time, ms
  localparam logic [7:0] OFS_AVG_TIME = 8'h08;  // Moving average time, ms
  localparam logic [7:0] OFS_COMMON   = 8'h0C;  // Common accel [15:0], decel [31:16]
  localparam logic [7:0] OFS_PRESET   = 8'h10;  // Preset position
  localparam logic [7:0] OFS_ENC_PRE  = 8'h14;  // Encoder counter preset
  localparam logic [7:0] OFS_BAND     = 8'h18;  // Detection band, 0.1 deg
  localparam logic [7:0] OFS_ENC_RES  = 8'h1C;  // Encoder resolution, P/R
  localparam logic [7:0] OFS_MOT_RES  = 8'h20;  // Motor resolution, P/R
  localparam logic [7:0] OFS_ACTION   = 8'h24;  // Write-one command strobes
  localparam logic [7:0] OFS_STATUS   = 8'h28;  // Supervision state
  localparam logic [7:0] OFS_CMD_POS  = 8'h2C;  // Command position
  localparam logic [7:0] OFS_ENC_CNT  = 8'h30;  // Encoder counter
  localparam logic [7:0] OFS_FB_POS   = 8'h34;  // Feedback position

  // Command strobe bits
  localparam int unsigned ACT_CLEAR   = 0;  // Clear position counters
  localparam int unsigned ACT_ENC_PRE = 1;  // Preset encoder counter

  // Reset values
  localparam logic [7:0]  SPD_FILT_RST = 8'h01;
  localparam logic [7:0]  AVG_TIME_RST = 8'h01;
  localparam logic [11:0] BAND_RST     = 12'h048;   // 72 tenths of a degree
  localparam logic [13:0] ENC_RES_RST  = 14'h01F4;  // 500 P/R
  localparam logic [17:0] MOT_RES_RST  = 18'h001F4; // 500 P/R
  localparam logic [2:0]  OUT_SEL_RST  = 3'h0;      // First terminal
  localparam int unsigned NUM_TERMS    = 6;         // General output terminals

  // Reaction to a deviation error
  typedef enum logic [1:0] {
    ACT_NONE  = 2'b00,
    ACT_WARN  = 2'b01,
    ACT_ALARM = 2'b10
  } dev_action_t;

  // Configuration word as stored and read back
  typedef struct packed {
    logic [2:0]  out_sel;     // [10:8] terminal carrying the deviation flag
    dev_action_t action;      // [5:4]
    logic        misstep_en;  // [2]
    logic        filt_avg;    // [1] 0 speed filter, 1 moving average
    logic        accel_sep;   // [0] 0 common, 1 separate
  } cfg_t;
  localparam cfg_t CFG_RST = '{out_sel: OUT_SEL_RST, action: ACT_NONE,
                               misstep_en: 1'b0, filt_avg: 1'b0, accel_sep: 1'b1};

  // Acceleration pair handed to the profile generator
  typedef struct packed {
    logic [15:0] decel;
    logic [15:0] accel;
  } rates_t;

  // Serial divider states
  typedef enum logic [0:0] {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } div_state_t;

endpackage

// ===== core/stepper_position_monitor.sv
// Profile shaping, position counters and misstep supervision for a stepper drive
//
// Summary of operation
// - Accel source: common rates or entry rates
// - Chained entries use the first entry's rates
// - Filter choice: speed filter or moving average
// - Speed filter time zero bypasses the filter
// - Moving average stretches each ramp by time
// - Signed 32-bit command position counts steps
// - Successful homing clears command position
// - Preset input loads command position preset
// - De-energized with misstep on: follow encoder
// - Quadrature decoded at four counts per cycle
// - Encoder preset command loads encoder preset
// - Encoder always counts; counter and feedback shown
// - Misstep enable switches deviation supervision
// - Error when deviation reaches the detection band
// - Check after 500 ms excited, not homing
// - Reaction: none, warning or alarm
// - Deviation flag routed to chosen output terminal
// - Error cleared by de-excite, homing, clear
// - Alarm needs alarm clear and deviation reset, in either order
`timescale 1ns/1ps
module stepper_position_monitor
  import stepper_pkg::*;
#(
  parameter int unsigned MS_CYCLES  = CYC_PER_MS,    // Cycles per millisecond
  parameter int unsigned SET_CYCLES = SETTLE_CYCLES  // Excitation settle cycles
) (
  input  wire logic        CLK_IN,          // 125 MHz clock
  input  wire logic        RESET_IN,        // Synchronous reset, active high
  input  wire logic        PSEL_IN,         // APB select
  input  wire logic        PENABLE_IN,      // APB access phase
  input  wire logic        PWRITE_IN,       // APB direction
  input  wire logic [7:0]  PADDR_IN,        // APB byte address
  input  wire logic [31:0] PWDATA_IN,       // APB write data
  output logic      [31:0] PRDATA_OUT,      // APB read data
  output logic             PREADY_OUT,      // APB ready
  output logic             PSLVERR_OUT,     // APB error, unmapped address
  input  wire logic        ENC_A_IN,        // Encoder phase A pin
  input  wire logic        ENC_B_IN,        // Encoder phase B pin
  input  wire logic        ALARM_CLEAR_IN,  // Alarm clear pin
  input  wire logic        PRESET_IN,       // Position preset pin
  input  wire logic        STEP_IN,         // Issued step pulse, one cycle
  input  wire logic        STEP_DIR_IN,     // Step direction, 1 forward
  input  wire logic        EXCITED_IN,      // Motor energized level
  input  wire logic        HOME_DONE_IN,    // Homing finished well, pulse
  input  wire logic        MECH_HOMING_IN,  // Mechanical homing in progress
  input  wire logic        ENTRY_START_IN,  // Operation entry starts, pulse
  input  wire logic        ENTRY_LINKED_IN, // Entry continues a chain
  input  wire rates_t      ENTRY_RATES_IN,  // Rates stored with the entry
  input  wire logic [15:0] SPEED_IN,        // Commanded speed
  output rates_t           RATES_OUT,       // Rates for the profile
  output logic      [15:0] SPEED_OUT,       // Filtered speed
  output logic [NUM_TERMS-1:0] TERM_OUT,    // General output terminals
  output logic             WARN_OUT,        // Excess deviation warning
  output logic             ALARM_OUT        // Excess deviation alarm
);

  // Synchronisers for pin inputs
  logic [3:0] sync1_q;      // First stage, read only by second
  logic [3:0] sync2_q;      // Second stage
  logic [3:0] sync3_q;      // Previous value for edge detection
  wire        enc_a    = sync2_q[0];
  wire        enc_b    = sync2_q[1];
  wire        clr_pin  = sync2_q[2];
  wire        pre_pin  = sync2_q[3];
  wire        clr_rise = clr_pin & ~sync3_q[2];
  wire        pre_rise = pre_pin & ~sync3_q[3];

  // Two flip-flops per pin before any use
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
    end else begin
      sync1_q <= {PRESET_IN, ALARM_CLEAR_IN, ENC_B_IN, ENC_A_IN};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Software-visible settings
  cfg_t          cfg_q;       // Mode bits
  logic [7:0]    spd_ms_q;    // Speed filter time
  logic [7:0]    avg_ms_q;    // Moving average time
  rates_t        common_q;    // Common rates
  logic [31:0]   preset_q;    // Preset position
  logic [31:0]   enc_pre_q;   // Encoder counter preset
  logic [11:0]   band_q;      // Detection band
  logic [13:0]   enc_res_q;   // Encoder resolution
  logic [17:0]   mot_res_q;   // Motor resolution
  logic [31:0]   cmd_pos_q;   // Command position
  logic [31:0]   enc_cnt_q;   // Encoder counter
  logic [31:0]   fb_pos_q;    // Feedback position
  logic          dev_err_q;   // Deviation error
  logic          alarm_q;     // Alarm latched
  logic          ack_seen_q;  // Alarm clear received while alarmed
  logic          checking_q;  // Supervision window open

  // APB decode: one wait state, write lands on the acknowledged edge
  wire  access  = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire  wr      = access & PWRITE_IN;
  wire  mapped  = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN <= OFS_FB_POS);
  wire  wr_ok   = wr & mapped;
  wire  do_clr  = wr_ok && PADDR_IN == OFS_ACTION && PWDATA_IN[ACT_CLEAR];
  wire  do_epre = wr_ok && PADDR_IN == OFS_ACTION && PWDATA_IN[ACT_ENC_PRE];
  logic [31:0] rd_mux;

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR_IN)
      OFS_CONFIG:   rd_mux = {21'h0, cfg_q.out_sel, 2'h0, cfg_q.action, 1'b0,
                              cfg_q.misstep_en, cfg_q.filt_avg, cfg_q.accel_sep};
      OFS_SPD_FILT: rd_mux = {24'h0, spd_ms_q};
      OFS_AVG_TIME: rd_mux = {24'h0, avg_ms_q};
      OFS_COMMON:   rd_mux = common_q;
      OFS_PRESET:   rd_mux = preset_q;
      OFS_ENC_PRE:  rd_mux = enc_pre_q;
      OFS_BAND:     rd_mux = {20'h0, band_q};
      OFS_ENC_RES:  rd_mux = {18'h0, enc_res_q};
      OFS_MOT_RES:  rd_mux = {14'h0, mot_res_q};
      OFS_STATUS:   rd_mux = {28'h0, checking_q, alarm_q, WARN_OUT, dev_err_q};
      OFS_CMD_POS:  rd_mux = cmd_pos_q;
      OFS_ENC_CNT:  rd_mux = enc_cnt_q;
      OFS_FB_POS:   rd_mux = fb_pos_q;
      default:      rd_mux = 32'h0000_0000;  // Strobes and holes read zero
    endcase
  end

  // Bus answer registers
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      PRDATA_OUT  <= rd_mux;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~mapped;
    end
  end

  // Setting registers
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      cfg_q     <= CFG_RST;
      spd_ms_q  <= SPD_FILT_RST;
      avg_ms_q  <= AVG_TIME_RST;
      common_q  <= '0;
      preset_q  <= 32'h0000_0000;
      enc_pre_q <= 32'h0000_0000;
      band_q    <= BAND_RST;
      enc_res_q <= ENC_RES_RST;
      mot_res_q <= MOT_RES_RST;
    end else if (wr_ok) begin
      case (PADDR_IN)
        OFS_CONFIG:   cfg_q     <= '{out_sel: PWDATA_IN[10:8],
                                     action: dev_action_t'(PWDATA_IN[5:4]),
                                     misstep_en: PWDATA_IN[2], filt_avg: PWDATA_IN[1],
                                     accel_sep: PWDATA_IN[0]};
        OFS_SPD_FILT: spd_ms_q  <= PWDATA_IN[7:0];
        OFS_AVG_TIME: avg_ms_q  <= PWDATA_IN[7:0];
        OFS_COMMON:   common_q  <= PWDATA_IN;
        OFS_PRESET:   preset_q  <= PWDATA_IN;
        OFS_ENC_PRE:  enc_pre_q <= PWDATA_IN;
        OFS_BAND:     band_q    <= PWDATA_IN[11:0];
        OFS_ENC_RES:  enc_res_q <= PWDATA_IN[13:0];  // Host keeps a multiple of 50
        OFS_MOT_RES:  mot_res_q <= PWDATA_IN[17:0];
        default:      ;  // Read-only or strobe
      endcase
    end
  end

  // Chain rates: latched at a chain's first entry only
  rates_t chain_q;
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      chain_q   <= '0;
      RATES_OUT <= '0;
    end else begin
      if (ENTRY_START_IN && !ENTRY_LINKED_IN)
        chain_q <= ENTRY_RATES_IN;
      RATES_OUT <= cfg_q.accel_sep ? chain_q : common_q;
    end
  end

  // Speed filters share one output register
  logic [24:0] ms_cnt_q;    // Millisecond divider
  logic [15:0] tgt_q;       // Ramp target for averaging
  logic [15:0] step_q;      // Magnitude of the ramp
  logic        up_q;        // Ramp direction
  logic [25:0] err_q;       // Spreads ramp steps evenly over the window
  wire         ms_tick  = (ms_cnt_q == 25'(MS_CYCLES - 1));
  wire  [24:0] span     = 25'(avg_ms_q * MS_CYCLES);  // Window in cycles
  wire  [25:0] err_sum  = err_q + {10'h0, step_q};
  wire  [16:0] gap      = {1'b0, SPEED_IN} - {1'b0, SPEED_OUT};
  logic [3:0]  shift;       // Time constant as a power of two

  // Nearest power of two above the speed filter time
  always_comb begin
    shift = 4'h0;
    for (int i = 0; i < 8; i++)
      if (spd_ms_q[i]) shift = 4'(i + 1);
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ms_cnt_q  <= 25'h0;
      SPEED_OUT <= 16'h0000;
      tgt_q     <= 16'h0000;
      step_q    <= 16'h0000;
      up_q      <= 1'b0;
      err_q     <= 26'h0;
    end else begin
      ms_cnt_q <= ms_tick ? 25'h0 : ms_cnt_q + 25'h1;
      if (!cfg_q.filt_avg) begin
        tgt_q <= SPEED_OUT;
        if (spd_ms_q == 8'h00)
          SPEED_OUT <= SPEED_IN;
        else if (ms_tick)
          SPEED_OUT <= SPEED_OUT + 16'($signed(gap) >>> shift);  // First order lag
      end else if (avg_ms_q == 8'h00) begin
        SPEED_OUT <= SPEED_IN;
        tgt_q     <= SPEED_IN;
      end else if (SPEED_IN != tgt_q) begin
        // New target: restart the linear ramp from the present speed
        tgt_q  <= SPEED_IN;
        up_q   <= ~gap[16];
        step_q <= gap[16] ? 16'(-gap) : gap[15:0];
        err_q  <= 26'h0;
      end else if (SPEED_OUT != tgt_q) begin
        // Ramp takes exactly the averaging time
        if (err_sum >= {1'b0, span}) begin
          err_q     <= err_sum - {1'b0, span};
          SPEED_OUT <= up_q ? SPEED_OUT + 16'h1 : SPEED_OUT - 16'h1;
        end else begin
          err_q <= err_sum;
        end
      end
    end
  end

  // Quadrature decode: count every edge of either phase
  logic [1:0] ab_q;
  wire        ab_edge = ({enc_a, enc_b} != ab_q);
  wire        ab_fwd  = enc_a ^ ab_q[0];  // Direction from phase order

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ab_q      <= 2'h0;
      enc_cnt_q <= 32'h0000_0000;
    end else begin
      ab_q <= {enc_a, enc_b};
      if (do_clr)
        enc_cnt_q <= 32'h0000_0000;
      else if (do_epre)
        enc_cnt_q <= enc_pre_q;
      else if (ab_edge)
        enc_cnt_q <= ab_fwd ? enc_cnt_q + 32'h1 : enc_cnt_q - 32'h1;  // Always on
    end
  end

  // Feedback position = encoder count * motor res / (4 * encoder res)
  div_state_t  div_st_q;
  logic [5:0]  div_cnt_q;
  logic [55:0] num_q;
  logic [17:0] rem_q;
  logic [55:0] quo_q;
  logic        neg_q;
  wire  [31:0] enc_mag  = enc_cnt_q[31] ? -enc_cnt_q : enc_cnt_q;
  wire  [17:0] den      = {2'b00, enc_res_q, 2'b00};
  wire  [18:0] rem_sh   = {rem_q, num_q[55]};
  wire         fits     = rem_sh >= {1'b0, den};
  wire  [55:0] quo_nx   = {quo_q[54:0], fits};

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      div_st_q  <= DIV_IDLE;
      div_cnt_q <= 6'h0;
      num_q     <= 56'h0;
      rem_q     <= 18'h0;
      quo_q     <= 56'h0;
      neg_q     <= 1'b0;
      fb_pos_q  <= 32'h0000_0000;
    end else if (do_clr) begin  // Clear drops stale work
      div_st_q <= DIV_IDLE;
      fb_pos_q <= 32'h0000_0000;
    end else begin
      case (div_st_q)
        DIV_IDLE: begin
          num_q     <= 56'(enc_mag) * 56'(mot_res_q);
          neg_q     <= enc_cnt_q[31];
          rem_q     <= 18'h0;
          div_cnt_q <= 6'h0;
          div_st_q  <= DIV_RUN;
        end
        DIV_RUN: begin
          num_q     <= {num_q[54:0], 1'b0};
          rem_q     <= fits ? 18'(rem_sh - {1'b0, den}) : rem_sh[17:0];
          quo_q     <= quo_nx;
          div_cnt_q <= div_cnt_q + 6'h1;
          if (div_cnt_q == 6'd55) begin
            fb_pos_q <= neg_q ? -quo_nx[31:0] : quo_nx[31:0];
            div_st_q <= DIV_IDLE;
          end
        end
        default: div_st_q <= DIV_IDLE;
      endcase
    end
  end

  // Command position
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      cmd_pos_q <= 32'h0000_0000;
    end else if (do_clr || HOME_DONE_IN) begin
      cmd_pos_q <= 32'h0000_0000;
    end else if (pre_rise) begin
      cmd_pos_q <= preset_q;
    end else if (cfg_q.misstep_en && !EXCITED_IN) begin
      cmd_pos_q <= fb_pos_q;  // Follows even forced shaft motion
    end else if (STEP_IN) begin
      cmd_pos_q <= STEP_DIR_IN ? cmd_pos_q + 32'h1 : cmd_pos_q - 32'h1;  // Wraps
    end
  end

  // Supervision window and deviation compare
  logic [25:0] settle_q;   // Counts excited cycles
  wire  [32:0] diff     = {cmd_pos_q[31], cmd_pos_q} - {fb_pos_q[31], fb_pos_q};
  wire  [32:0] diff_mag = diff[32] ? -diff : diff;
  wire  [47:0] dev_lhs  = 48'(diff_mag * 48'(DEG_TENTHS_REV));
  wire  [47:0] dev_rhs  = 48'(band_q) * 48'(mot_res_q);
  wire         settled  = (settle_q == 26'(SET_CYCLES));
  wire         dev_rst  = !EXCITED_IN || MECH_HOMING_IN || do_clr;
  wire         dev_hit  = checking_q && !do_clr && (dev_lhs >= dev_rhs);

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      settle_q   <= 26'h0;
      checking_q <= 1'b0;
      dev_err_q  <= 1'b0;
    end else begin
      if (!EXCITED_IN)
        settle_q <= 26'h0;
      else if (!settled)
        settle_q <= settle_q + 26'h1;
      checking_q <= cfg_q.misstep_en && settled && EXCITED_IN && !MECH_HOMING_IN;
      if (dev_hit)
        dev_err_q <= 1'b1;  // Set wins over de-excite or homing; a clear command wins over set
      else if (dev_rst)
        dev_err_q <= 1'b0;
    end
  end

  // Reaction and output terminal routing
  wire alarm_end = ack_seen_q && !dev_err_q;

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      alarm_q    <= 1'b0;
      ack_seen_q <= 1'b0;
      WARN_OUT   <= 1'b0;
      ALARM_OUT  <= 1'b0;
    end else begin
      WARN_OUT <= dev_err_q && cfg_q.action == ACT_WARN;
      if (dev_err_q && cfg_q.action == ACT_ALARM) begin
        alarm_q <= 1'b1;
      end else if (alarm_end) begin
        alarm_q <= 1'b0;  // Needs both steps, in either order
      end
      if (!alarm_q || alarm_end)
        ack_seen_q <= 1'b0;
      else if (clr_rise)
        ack_seen_q <= 1'b1;  // Clear pin alone does not end the alarm
      ALARM_OUT <= alarm_q;
    end
  end

  // One flip-flop per terminal; only the selected one carries the flag
  for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
    always_ff @(posedge CLK_IN) begin
      if (RESET_IN)
        TERM_OUT[t] <= 1'b0;
      else
        TERM_OUT[t] <= dev_err_q && (cfg_q.out_sel == 3'(t));
    end
  end

endmodule // stepper_position_monitor

// ===== tb/enc_model.sv
// Behavioural motor shaft with quadrature encoder, moved by issued steps
`timescale 1ns/1ps
module enc_model (
  input  wire logic       clk_in,    // Bench clock
  input  wire logic       step_in,   // Issued step pulse
  input  wire logic       dir_in,    // 1 forward
  input  wire logic       slip_in,   // Shaft misses steps
  input  wire logic       push_in,   // External force, one step forward
  input  wire logic [1:0] gap_in,    // Idle cycles between edges
  output logic            enc_a_out, // Phase A
  output logic            enc_b_out  // Phase B
);
  int         pend = 0;   // Quarter counts still owed
  int         wait_c = 0; // Edge spacing count
  logic [1:0] ph = 2'h0;  // Gray phase index
  // Four edges per step; a slow gap lets the backlog pile up
  always @(posedge clk_in) begin
    if (push_in || (step_in && !slip_in))
      pend = pend + ((dir_in || push_in) ? 4 : -4);
    if (wait_c > 0)
      wait_c = wait_c - 1;
    else if (pend != 0) begin
      ph <= (pend > 0) ? ph + 2'h1 : ph - 2'h1;
      pend = (pend > 0) ? pend - 1 : pend + 1;
      wait_c = int'(gap_in);
    end
  end
  // Forward order 00,10,11,01 puts A ahead of B
  assign enc_a_out = ph[1] ^ ph[0];
  assign enc_b_out = ph[1];
endmodule // enc_model

// ===== tb/spm_checker_sva.sv
// Concurrent checks on the stepper position monitor ports
`timescale 1ns/1ps
module spm_checker
  import stepper_pkg::*;
(
  input wire logic                 CLK_IN,         // Core clock
  input wire logic                 RESET_IN,       // Synchronous reset
  input wire logic                 PSEL_IN,        // APB select
  input wire logic                 PENABLE_IN,     // APB access phase
  input wire logic                 EXCITED_IN,     // Motor energized
  input wire logic                 MECH_HOMING_IN, // Mechanical homing
  input wire logic                 PREADY_OUT,     // APB ready
  input wire logic                 PSLVERR_OUT,    // APB error
  input wire logic [NUM_TERMS-1:0] TERM_OUT,       // Output terminals
  input wire logic                 WARN_OUT        // Deviation warning
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // Access phase lasts exactly two cycles
  a_ready_timing: assert property ($rose(PENABLE_IN) && PSEL_IN |=> PREADY_OUT)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("ready outside an access");
  a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  a_term_single: assert property ($onehot0(TERM_OUT))
    else $error("flag on more than one terminal");
  // Pipeline margin of a few cycles after the cause
  a_deexcite_clear: assert property (!EXCITED_IN [*4] |-> TERM_OUT == '0 && !WARN_OUT)
    else $error("flag held while de-excited");
  a_homing_quiet: assert property (MECH_HOMING_IN [*4] |-> TERM_OUT == '0)
    else $error("flag held during homing");
  a_settle_guard: assert property ($rose(|TERM_OUT) |-> $past(EXCITED_IN, 8))
    else $error("flag before settle time");
endmodule // spm_checker

bind stepper_position_monitor spm_checker u_chk (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .EXCITED_IN(EXCITED_IN), .MECH_HOMING_IN(MECH_HOMING_IN), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .TERM_OUT(TERM_OUT), .WARN_OUT(WARN_OUT)
);

// ===== tb/tb_top.sv
// Self-checking bench for the stepper position monitor
`timescale 1ns/1ps
module tb_top
  import stepper_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1;                 // Clock, reset
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;    // APB controls
  logic [7:0]  paddr = 8'h00;                          // APB address
  logic [31:0] pwdata = 32'h0, prdata, pv, ev, cv;     // Data, random values
  logic        pready, pslverr, ea, eb, warn, alarm;   // Outputs, encoder
  logic        aclr = 1'b0, pre = 1'b0, step = 1'b0, dir = 1'b0;
  logic        exc = 1'b0, hdone = 1'b0, mhome = 1'b0, est = 1'b0;
  logic        elink = 1'b0, slip = 1'b0, push = 1'b0; // Entries, faults
  logic [1:0]  gap = 2'h0;                             // Encoder edge spacing
  rates_t      erates = 32'h0, rates;                  // Rates in and out
  logic [15:0] spd = 16'h0, spdo, sv;                  // Speed in and out
  logic [5:0]  term;                                   // Terminals
  logic [33:0] q[$], e;                                // Expected answers
  logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C, 8'h20};
  logic [31:0] rv[6] = '{32'h1, 32'h1, 32'h1, 32'h48, 32'h1F4, 32'h1F4};
  int          seed, num_errors = 0, checked = 0;

  // Short settle; two ms cover a full-scale ramp
  stepper_position_monitor #(.MS_CYCLES(32768), .SET_CYCLES(50)) DUT (
    .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .ENC_A_IN(ea), .ENC_B_IN(eb), .ALARM_CLEAR_IN(aclr),
    .PRESET_IN(pre), .STEP_IN(step), .STEP_DIR_IN(dir), .EXCITED_IN(exc),
    .HOME_DONE_IN(hdone), .MECH_HOMING_IN(mhome), .ENTRY_START_IN(est),
    .ENTRY_LINKED_IN(elink), .ENTRY_RATES_IN(erates), .SPEED_IN(spd), .RATES_OUT(rates),
    .SPEED_OUT(spdo), .TERM_OUT(term), .WARN_OUT(warn), .ALARM_OUT(alarm));
  enc_model u_motor (.clk_in(clk), .step_in(step), .dir_in(dir), .slip_in(slip),
    .push_in(push), .gap_in(gap), .enc_a_out(ea), .enc_b_out(eb));

  always #4 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic conclude;
    $display("Checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; the expected answer is queued first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    int n;
    n = 0;
    @(posedge clk);
    q.push_back(x);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) check("pready", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b10, x});
  endtask

  task automatic steps(input int n, input logic d);
    repeat (n) begin
      @(posedge clk);
      step <= 1'b1;
      dir <= d;
      @(posedge clk);
      step <= 1'b0;
    end
  endtask

  task automatic entry(input logic l, input logic [31:0] r);
    @(posedge clk);
    est <= 1'b1;
    elink <= l;
    erates <= r;
    @(posedge clk);
    est <= 1'b0;
  endtask

  // Oldest note is compared whenever the slave answers
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) check("extra", 32'h1, 32'h0);
      e = q.pop_front();
      check("pslverr", 32'(pslverr), 32'(e[32]));
      if (e[33]) check("prdata", prdata, e[31:0]);
    end
  end

  initial begin
    seed = 28;
    gap = 2'($random(seed));
    wt(3);
    rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    apb(1'b0, 8'h38, 32'h0, {2'b11, 32'h0});
    steps(5, 1'b1);
    steps(2, 1'b0);
    wt(250);
    rd(OFS_CMD_POS, 32'h3);
    rd(OFS_ENC_CNT, 32'hC);
    rd(OFS_FB_POS, 32'h3);
    @(posedge clk) hdone <= 1'b1;
    @(posedge clk) hdone <= 1'b0;
    rd(OFS_CMD_POS, 32'h0);
    pv = $random(seed);
    pv = {{8{pv[23]}}, pv[23:0]};
    ev = $random(seed);
    ev = {{8{ev[23]}}, ev[23:0]};
    wr(OFS_PRESET, pv);
    pre <= 1'b1;
    wt(6);
    pre <= 1'b0;
    rd(OFS_CMD_POS, pv);
    wr(OFS_ENC_PRE, ev);
    wr(OFS_ACTION, 32'h2);
    rd(OFS_ENC_CNT, ev);
    wr(OFS_ACTION, 32'h1);
    rd(OFS_CMD_POS, 32'h0);
    // Shaft turned by hand while de-excited
    wr(OFS_CONFIG, 32'h5);
    repeat (2) begin
      @(posedge clk) push <= 1'b1;
      @(posedge clk) push <= 1'b0;
    end
    wt(250);
    rd(OFS_CMD_POS, 32'h2);
    // Warning on terminal 2, band boundary at ten steps
    wr(OFS_ACTION, 32'h1);
    wr(OFS_CONFIG, 32'h215);
    wt(120);
    exc <= 1'b1;
    wt(20);
    rd(OFS_STATUS, 32'h0);
    wt(40);
    rd(OFS_STATUS, 32'h8);
    slip <= 1'b1;
    steps(9, 1'b1);
    wt(20);
    rd(OFS_STATUS, 32'h8);
    steps(1, 1'b1);
    wt(10);
    rd(OFS_STATUS, 32'hB);
    check("term", 32'(term), 32'h4);
    mhome <= 1'b1;
    wt(6);
    check("term", 32'(term), 32'h0);
    mhome <= 1'b0;
    exc <= 1'b0;
    wt(5);
    rd(OFS_STATUS, 32'h0);
    // Alarm needs clear input, then a deviation reset
    wr(OFS_ACTION, 32'h1);
    wr(OFS_CONFIG, 32'h225);
    wt(120);
    exc <= 1'b1;
    wt(60);
    steps(10, 1'b1);
    wt(10);
    check("alarm", 32'(alarm), 32'h1);
    aclr <= 1'b1;
    wt(6);
    aclr <= 1'b0;
    wt(6);
    check("alarm", 32'(alarm), 32'h1);
    wr(OFS_ACTION, 32'h1);
    wt(6);
    check("alarm", 32'(alarm), 32'h0);
    exc <= 1'b0;
    slip <= 1'b0;
    // Rate source and chained entries
    cv = $random(seed);
    wr(OFS_COMMON, cv);
    wr(OFS_CONFIG, 32'h0);
    entry(1'b0, ~cv);
    wt(3);
    check("rates", rates, cv);
    wr(OFS_CONFIG, 32'h1);
    entry(1'b0, pv);
    wt(3);
    check("rates", rates, pv);
    entry(1'b1, ev);
    wt(3);
    check("rates", rates, pv);
    // Filters: bypass, first order, moving average
    sv = 16'($random(seed));
    wr(OFS_SPD_FILT, 32'h0);
    spd <= sv;
    wt(3);
    check("speed", 32'(spdo), 32'(sv));
    wr(OFS_SPD_FILT, 32'h1);
    spd <= ~sv;
    wt(3);
    check("lag", 32'(spdo === ~sv), 32'h0);
    wr(OFS_CONFIG, 32'h2);
    wr(OFS_AVG_TIME, 32'h2);
    spd <= sv;
    wt(3);
    check("ramp", 32'(spdo === sv), 32'h0);
    wt(65600);
    check("speed", 32'(spdo), 32'(sv));
    conclude();
  end

  // Watchdog past the two-ms ramp at the end
  initial begin
    #640000;
    num_errors++;
    conclude();
  end
endmodule // tb_top
